// ### ptl_pkg.sv
package ptl_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PRESET = 8'h04;
  localparam logic [7:0] A_START  = 8'h08;
  localparam logic [7:0] A_END    = 8'h0C;
  localparam logic [7:0] A_RANGE  = 8'h10;
  localparam logic [7:0] A_ST_TMR = 8'h14;
  localparam logic [7:0] A_END_TMR = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_POS    = 8'h20;
  // Values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_TMR  = 16'h0000;
  // Field positions
  localparam int CTRL_DEDICATED = 0;
  localparam int ST_CMPL  = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_TIMER = 2;
  localparam int ST_OVF   = 3;
  localparam int ST_ARMED = 4;
  localparam int ST_RUN   = 5;
  localparam int ST_REV   = 6;
  // Synchronised pin positions
  localparam int IN_EN    = 0;
  localparam int IN_RUN   = 1;
  localparam int IN_ARM   = 2;
  localparam int IN_RECV  = 3;
  localparam int IN_RET   = 4;
  localparam int IN_PULSE = 5;
  localparam int IN_DIR   = 6;
  localparam int IN_Z     = 7;
  localparam int N_IN     = 8;
  // Timing
  localparam int CLK_NS      = 100;
  localparam int MS_NS       = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_NS;
  localparam int END_MIN_MS  = 500;
  localparam int HOLD_MS     = 100;
  // Position count limits
  localparam logic signed [31:0] POS_MAX = 32'sh0098_967F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_STARTING, ST_RUNNING, ST_END_WAIT, ST_DONE
  } ptl_state_e;
endpackage

// ### ptl_positioning_terminal_logic.sv
// Function
// - a rising Z edge after limit_switch_arm rises loads the preset position.
// - limit_switch_arm has no other effect on the count or any state.
// - positioning control works only while positioning enable is on.
// - in shared mode, pulses count toward the end point only with receive on.
// - in dedicated mode, pulses count toward the end point at all times.
// - each rise of serial_pulse_receive clears the end point count.
// - a start with return_mode on runs reverse, stored points unchanged.
// - alarm rises after the end timer (at least 0.5 s) if out of range.
// - timer output is on from start timer begin until end timer expiry.
// - cancelling the end timer stops the drive and drops timer output.
// - overflow rises when the position leaves +-9,999,999, always.
// - overflow clears on return to range, run start when enabled, or Z load.
// - after the end timer, completion rises when deviation is in range.
// - completion and alarm stay on at least 100 ms once raised.
// - the start timer delays the drive after an enabled run command.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module ptl_positioning_terminal_logic #(
  parameter int TICK_CYCLES = ptl_pkg::TICK_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  input  wire logic        positioning_enable_in,
  input  wire logic        run_cmd_in,
  input  wire logic        limit_switch_arm_in,
  input  wire logic        serial_pulse_receive_in,
  input  wire logic        return_mode_in,
  input  wire logic        enc_pulse_in,
  input  wire logic        enc_dir_in,
  input  wire logic        enc_z_in,
  input  wire logic        motor_stopped_in,
  output logic             stop_position_alarm_out,
  output logic             timer_output_out,
  output logic             positioning_completed_out,
  output logic             position_overflow_out,
  output logic             drive_run_out,
  output logic             reverse_dir_out
);
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Magnitude of the difference of two signed counts
  function automatic logic [32:0] absdiff(input logic signed [31:0] a,
                                          input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'({a[31], a}) - 33'({b[31], b});
    return d[32] ? 33'(-d) : 33'(d);
  endfunction

  logic [7:0]  pins;
  logic [7:0]  s1_ff, s2_ff, s3_ff, in_ff, inq_ff, nxt_in;
  logic [7:0]  rise;
  logic        en, run, pulse_rise, z_rise;
  logic [31:0] tick_ff, nxt_tick;
  logic        tick;

  // Pin synchronisers; a change counts once stages two and three agree
  assign pins = {enc_z_in, enc_dir_in, enc_pulse_in, return_mode_in,
                 serial_pulse_receive_in, limit_switch_arm_in,
                 run_cmd_in, positioning_enable_in};
  always_comb begin
    nxt_in = in_ff;
    for (int i = 0; i < ptl_pkg::N_IN; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_in[i] = s3_ff[i];
      end
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_ff  <= 8'h00;
      s2_ff  <= 8'h00;
      s3_ff  <= 8'h00;
      in_ff  <= 8'h00;
      inq_ff <= 8'h00;
    end else begin
      s1_ff  <= pins;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      in_ff  <= nxt_in;
      inq_ff <= in_ff;
    end
  end
  assign rise       = in_ff & ~inq_ff;
  assign en         = in_ff[ptl_pkg::IN_EN];
  assign run        = in_ff[ptl_pkg::IN_RUN];
  assign pulse_rise = rise[ptl_pkg::IN_PULSE];
  assign z_rise     = rise[ptl_pkg::IN_Z];

  // Millisecond enable; timers count in whole ms to keep counters narrow
  always_comb begin
    tick     = (tick_ff == 32'(TICK_CYCLES - 1));
    nxt_tick = tick ? 32'h0000_0000 : tick_ff + 32'h0000_0001;
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_ff <= ptl_pkg::RST_WORD;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  // Bus slave state and software registers
  logic        aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] ctrl_ff, preset_ff, start_ff, range_ff;
  logic [15:0] st_tmr_ff, et_tmr_ff;
  logic        nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
  logic [7:0]  nxt_awaddr;
  logic [31:0] nxt_wdata, nxt_rdata;
  logic [3:0]  nxt_wstrb;
  logic [1:0]  nxt_bresp, nxt_rresp;
  logic [31:0] nxt_ctrl, nxt_preset, nxt_start, nxt_range;
  logic [15:0] nxt_st_tmr, nxt_et_tmr;
  logic        wr_fire, wr_end;
  logic [31:0] status, end_pt_ff;
  logic signed [31:0] pos_ff;

  // Address and data are taken in either order; response after both
  always_comb begin
    awready_out = !aw_got_ff && !bvalid_ff;
    wready_out  = !w_got_ff && !bvalid_ff;
    arready_out = !rvalid_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff && !bready_in;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff && !rready_in;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_preset = preset_ff;
    nxt_start  = start_ff;
    nxt_range  = range_ff;
    nxt_st_tmr = st_tmr_ff;
    nxt_et_tmr = et_tmr_ff;
    wr_end     = 1'b0;
    if (awvalid_in && awready_out) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      nxt_w_got = 1'b1;
      nxt_wdata = wdata_in;
      nxt_wstrb = wstrb_in;
    end
    wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = ptl_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        ptl_pkg::A_CTRL:   nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff);
        ptl_pkg::A_PRESET: nxt_preset = merge(preset_ff, wdata_ff, wstrb_ff);
        ptl_pkg::A_START:  nxt_start = merge(start_ff, wdata_ff, wstrb_ff);
        ptl_pkg::A_END:    wr_end = 1'b1;
        ptl_pkg::A_RANGE:  nxt_range = merge(range_ff, wdata_ff, wstrb_ff);
        ptl_pkg::A_ST_TMR: nxt_st_tmr = 16'(merge({16'h0000, st_tmr_ff},
                                                  wdata_ff, wstrb_ff));
        ptl_pkg::A_END_TMR: nxt_et_tmr = 16'(merge({16'h0000, et_tmr_ff},
                                                   wdata_ff, wstrb_ff));
        ptl_pkg::A_STATUS, ptl_pkg::A_POS: nxt_bresp = ptl_pkg::RESP_OKAY;
        default:           nxt_bresp = ptl_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid_in && arready_out) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = ptl_pkg::RESP_OKAY;
      unique case (araddr_in)
        ptl_pkg::A_CTRL:   nxt_rdata = ctrl_ff;
        ptl_pkg::A_PRESET: nxt_rdata = preset_ff;
        ptl_pkg::A_START:  nxt_rdata = start_ff;
        ptl_pkg::A_END:    nxt_rdata = end_pt_ff;
        ptl_pkg::A_RANGE:  nxt_rdata = range_ff;
        ptl_pkg::A_ST_TMR: nxt_rdata = {16'h0000, st_tmr_ff};
        ptl_pkg::A_END_TMR: nxt_rdata = {16'h0000, et_tmr_ff};
        ptl_pkg::A_STATUS: nxt_rdata = status;
        ptl_pkg::A_POS:    nxt_rdata = pos_ff;
        default: begin
          nxt_rdata = ptl_pkg::RST_WORD;
          nxt_rresp = ptl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= ptl_pkg::RST_WORD;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= ptl_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= ptl_pkg::RST_WORD;
      rresp_ff  <= ptl_pkg::RESP_OKAY;
      ctrl_ff   <= ptl_pkg::RST_WORD;
      preset_ff <= ptl_pkg::RST_WORD;
      start_ff  <= ptl_pkg::RST_WORD;
      range_ff  <= ptl_pkg::RST_WORD;
      st_tmr_ff <= ptl_pkg::RST_TMR;
      et_tmr_ff <= ptl_pkg::RST_TMR;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      ctrl_ff   <= nxt_ctrl;
      preset_ff <= nxt_preset;
      start_ff  <= nxt_start;
      range_ff  <= nxt_range;
      st_tmr_ff <= nxt_st_tmr;
      et_tmr_ff <= nxt_et_tmr;
    end
  end
  assign bvalid_out = bvalid_ff;
  assign bresp_out  = bresp_ff;
  assign rvalid_out = rvalid_ff;
  assign rdata_out  = rdata_ff;
  assign rresp_out  = rresp_ff;

  // Position, arming, end point count and overflow
  logic signed [31:0] nxt_pos;
  logic        armed_ff, nxt_armed, ovf_ff, nxt_ovf, oor, oorq_ff;
  logic        zcorr, ded, run_start;
  logic [31:0] nxt_end_pt;
  always_comb begin
    ded       = ctrl_ff[ptl_pkg::CTRL_DEDICATED];
    run_start = en && rise[ptl_pkg::IN_RUN];
    zcorr     = armed_ff && z_rise;
    nxt_pos   = pos_ff;
    nxt_armed = armed_ff;
    if (pulse_rise) begin
      nxt_pos = in_ff[ptl_pkg::IN_DIR] ? pos_ff - 32'sd1 : pos_ff + 32'sd1;
    end
    if (zcorr) begin
      nxt_pos   = preset_ff;
      nxt_armed = 1'b0;
    end
    if (rise[ptl_pkg::IN_ARM]) begin
      nxt_armed = 1'b1;
    end
    nxt_end_pt = wr_end ? merge(end_pt_ff, wdata_ff, wstrb_ff) : end_pt_ff;
    if (rise[ptl_pkg::IN_RECV]) begin
      nxt_end_pt = ptl_pkg::RST_WORD;
    end else if (pulse_rise && (ded || in_ff[ptl_pkg::IN_RECV])) begin
      nxt_end_pt = end_pt_ff + 32'h0000_0001;
    end
    // Held wider than the limits so leaving the range is seen
    oor = (pos_ff > ptl_pkg::POS_MAX) ||
          (pos_ff < -ptl_pkg::POS_MAX);
    nxt_ovf = ovf_ff;
    if (!oor || run_start || zcorr) begin
      nxt_ovf = 1'b0;
    end
    if (oor && !oorq_ff) begin
      nxt_ovf = 1'b1;
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pos_ff    <= ptl_pkg::RST_WORD;
      armed_ff  <= 1'b0;
      end_pt_ff <= ptl_pkg::RST_WORD;
      ovf_ff    <= 1'b0;
      oorq_ff   <= 1'b0;
    end else begin
      pos_ff    <= nxt_pos;
      armed_ff  <= nxt_armed;
      end_pt_ff <= nxt_end_pt;
      ovf_ff    <= nxt_ovf;
      oorq_ff   <= oor;
    end
  end

  // Positioning sequencer
  ptl_pkg::ptl_state_e state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt, hold_ff, nxt_hold, et_lim;
  logic        ret_ff, nxt_ret, inrng_ff, nxt_inrng, near;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_hold  = hold_ff;
    nxt_ret   = ret_ff;
    nxt_inrng = inrng_ff;
    // Short end timer settings still wait the minimum
    et_lim = (et_tmr_ff < 16'(ptl_pkg::END_MIN_MS)) ?
             16'(ptl_pkg::END_MIN_MS) : et_tmr_ff;
    near = absdiff(pos_ff, ret_ff ? start_ff : end_pt_ff) <=
           {1'b0, range_ff};
    unique case (state_ff)
      ptl_pkg::ST_IDLE: begin
        if (run_start) begin
          nxt_state = ptl_pkg::ST_STARTING;
          nxt_cnt   = 16'h0000;
          nxt_ret   = in_ff[ptl_pkg::IN_RET];
        end
      end
      ptl_pkg::ST_STARTING: begin
        if (!run) begin
          nxt_state = ptl_pkg::ST_IDLE;
        end else if (cnt_ff >= st_tmr_ff) begin
          nxt_state = ptl_pkg::ST_RUNNING;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      ptl_pkg::ST_RUNNING: begin
        if (!run) begin
          nxt_state = ptl_pkg::ST_IDLE;
        end else if (motor_stopped_in) begin
          nxt_state = ptl_pkg::ST_END_WAIT;
          nxt_cnt   = 16'h0000;
        end
      end
      ptl_pkg::ST_END_WAIT: begin
        if (!run) begin
          nxt_state = ptl_pkg::ST_IDLE;
        end else if (cnt_ff >= et_lim) begin
          nxt_state = ptl_pkg::ST_DONE;
          nxt_inrng = near;
          nxt_hold  = 16'h0000;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      ptl_pkg::ST_DONE: begin
        // Result stays up at least the hold time even if disabled
        if (hold_ff < 16'(ptl_pkg::HOLD_MS)) begin
          nxt_hold = tick ? hold_ff + 16'h0001 : hold_ff;
        end else if (run_start) begin
          nxt_state = ptl_pkg::ST_STARTING;
          nxt_cnt   = 16'h0000;
          nxt_ret   = in_ff[ptl_pkg::IN_RET];
        end else if (!en) begin
          nxt_state = ptl_pkg::ST_IDLE;
        end
      end
    endcase
    if (!en && state_ff != ptl_pkg::ST_DONE) begin
      nxt_state = ptl_pkg::ST_IDLE;
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ptl_pkg::ST_IDLE;
      cnt_ff   <= ptl_pkg::RST_TMR;
      hold_ff  <= ptl_pkg::RST_TMR;
      ret_ff   <= 1'b0;
      inrng_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      hold_ff  <= nxt_hold;
      ret_ff   <= nxt_ret;
      inrng_ff <= nxt_inrng;
    end
  end

  // Terminal outputs decoded from sequencer flops; overflow comes from ovf_ff
  assign positioning_completed_out = (state_ff == ptl_pkg::ST_DONE) &&
                                     inrng_ff;
  assign stop_position_alarm_out = (state_ff == ptl_pkg::ST_DONE) &&
                                   !inrng_ff;
  assign timer_output_out = (state_ff == ptl_pkg::ST_STARTING) ||
                            (state_ff == ptl_pkg::ST_RUNNING) ||
                            (state_ff == ptl_pkg::ST_END_WAIT);
  assign drive_run_out         = (state_ff == ptl_pkg::ST_RUNNING);
  assign reverse_dir_out       = ret_ff;
  assign position_overflow_out = ovf_ff;
  assign status = {25'h000_0000, reverse_dir_out, drive_run_out, armed_ff,
                   ovf_ff, timer_output_out, stop_position_alarm_out,
                   positioning_completed_out};

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence seq_end_expire;
    state_ff == ptl_pkg::ST_END_WAIT ##1 state_ff == ptl_pkg::ST_DONE;
  endsequence
  sequence seq_arm_then_z;
    armed_ff && z_rise;
  endsequence

  AST_Z_PRESET: assert property (seq_arm_then_z |=> pos_ff == $past(preset_ff))
    else $error("Z edge after arming did not load preset");
  AST_ARM_NO_EFFECT: assert property (rise[ptl_pkg::IN_ARM] && !pulse_rise &&
    !z_rise |=> $stable(pos_ff))
    else $error("arming changed the position");
  AST_DISABLE: assert property (!en && state_ff != ptl_pkg::ST_DONE
    |=> state_ff == ptl_pkg::ST_IDLE)
    else $error("sequencer ran while disabled");
  AST_SHARED_GATE: assert property (!ded && !in_ff[ptl_pkg::IN_RECV] &&
    !rise[ptl_pkg::IN_RECV] && !wr_end |=> $stable(end_pt_ff))
    else $error("end point counted while receive off");
  AST_DEDICATED: assert property (ded && pulse_rise && !wr_end &&
    !rise[ptl_pkg::IN_RECV] |=> end_pt_ff == $past(end_pt_ff) + 1)
    else $error("dedicated pulse not counted");
  AST_RECV_CLEAR: assert property (rise[ptl_pkg::IN_RECV]
    |=> end_pt_ff == 32'h0000_0000)
    else $error("end point not cleared");
  AST_RETURN: assert property (state_ff == ptl_pkg::ST_IDLE && run_start
    |=> reverse_dir_out == $past(in_ff[ptl_pkg::IN_RET]))
    else $error("return mode not latched at start");
  AST_ALARM: assert property (seq_end_expire |-> stop_position_alarm_out ==
    !$past(near) && cnt_ff >= 16'(ptl_pkg::END_MIN_MS))
    else $error("alarm wrong after end timer");
  AST_TIMER_SPAN: assert property (run_start && state_ff == ptl_pkg::ST_IDLE
    |=> timer_output_out)
    else $error("timer output not raised at start");
  AST_CANCEL: assert property (state_ff == ptl_pkg::ST_END_WAIT && !run
    |=> !timer_output_out && !drive_run_out)
    else $error("cancel did not stop drive");
  AST_OVF_SET: assert property (oor && !oorq_ff |=> ovf_ff)
    else $error("overflow not raised");
  AST_OVF_CLR: assert property (!oor |=> !ovf_ff)
    else $error("overflow not cleared in range");
  AST_DONE_OK: assert property (seq_end_expire |->
    positioning_completed_out == $past(near))
    else $error("completion wrong after end timer");
  AST_HOLD: assert property ($fell(state_ff == ptl_pkg::ST_DONE)
    |-> $past(hold_ff) >= 16'(ptl_pkg::HOLD_MS))
    else $error("result dropped before hold time");
  AST_START_WAIT: assert property (state_ff == ptl_pkg::ST_STARTING &&
    cnt_ff < st_tmr_ff |=> !drive_run_out)
    else $error("drive started before start timer");
endmodule

// ### ptl_enc_model.sv
`timescale 1ns/1ns
// Encoder stand-in: count pulses and Z marks, changed after rising edges
module ptl_enc_model (
  input  wire logic clock_in,
  output logic      enc_pulse_out,
  output logic      enc_dir_out,
  output logic      enc_z_out
);
  // Idle low between marks
  initial begin
    enc_pulse_out = 1'b0;
    enc_dir_out   = 1'b0;
    enc_z_out     = 1'b0;
  end
  // Wide pulses so the pin filter never drops one
  task automatic pulses(input int n, input logic dn);
    enc_dir_out <= dn;
    repeat (n) begin
      repeat (6) @(posedge clock_in);
      enc_pulse_out <= 1'b1;
      repeat (6) @(posedge clock_in);
      enc_pulse_out <= 1'b0;
    end
    repeat (8) @(posedge clock_in);
  endtask
  // One Z mark, then time for the count to land
  task automatic zmark();
    enc_z_out <= 1'b1;
    repeat (6) @(posedge clock_in);
    enc_z_out <= 1'b0;
    repeat (8) @(posedge clock_in);
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clock_in = 1'b0, reset_n_in = 1'b0;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000, rdata_out, rv;
  logic [3:0] wstrb_in = 4'hf;
  logic awvalid_in = 0, wvalid_in = 0, bready_in = 0;
  logic arvalid_in = 0, rready_in = 0, motor_stopped_in = 0;
  logic positioning_enable_in = 0, run_cmd_in = 0, return_mode_in = 0;
  logic limit_switch_arm_in = 0, serial_pulse_receive_in = 0;
  logic [1:0] bresp_out, rresp_out, rs;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic stop_position_alarm_out, timer_output_out, drive_run_out;
  logic positioning_completed_out, position_overflow_out;
  logic reverse_dir_out, enc_pulse_in, enc_dir_in, enc_z_in;
  int miscompares = 0, cmp_count = 0;
  // Free-running 10 MHz clock
  always #50 clock_in = ~clock_in;
  // Short millisecond tick keeps the timed waits brief
  ptl_positioning_terminal_logic #(.TICK_CYCLES(2)) DUT (
    .clock_in, .reset_n_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out,
    .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
    .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .positioning_enable_in, .run_cmd_in, .limit_switch_arm_in,
    .serial_pulse_receive_in, .return_mode_in, .enc_pulse_in,
    .enc_dir_in, .enc_z_in, .motor_stopped_in, .stop_position_alarm_out,
    .timer_output_out, .positioning_completed_out,
    .position_overflow_out, .drive_run_out, .reverse_dir_out);
  ptl_enc_model enc (.clock_in, .enc_pulse_out(enc_pulse_in),
    .enc_dir_out(enc_dir_in), .enc_z_out(enc_z_in));
  task automatic st(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do begin
      @(negedge clock_in);
      aw = awready_out;
      w = wready_out;
      b = bvalid_out;
      rs = bresp_out;
      @(posedge clock_in);
      if (aw) awvalid_in <= 1'b0;
      if (w) wvalid_in <= 1'b0;
    end while (!b);
    bready_in <= 1'b0;
    // One idle edge so a following call never reassigns bready at once
    @(posedge clock_in);
  endtask
  // Read: ready, valid and data all sampled mid-cycle, at the falling edge
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do begin
      @(negedge clock_in);
      ar = arready_out;
      r = rvalid_out;
      rv = rdata_out;
      rs = rresp_out;
      @(posedge clock_in);
      if (ar) arvalid_in <= 1'b0;
    end while (!r);
    rready_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard, well beyond the longest expected run
  initial begin
    st(30000);
    miscompares++;
    results;
  end
  // Test sequence
  initial begin
    st(10);
    reset_n_in <= 1'b1;
    st(4);
    rd(ptl_pkg::A_CTRL);
    chk(rv, ptl_pkg::RST_WORD);
    rd(8'h24);
    chk(rs, ptl_pkg::RESP_SLVERR);
    wr(8'h24, 32'h0000_0001);
    chk(rs, ptl_pkg::RESP_SLVERR);
    $display("test bus done");
    wr(ptl_pkg::A_PRESET, 32'h0000_0064);
    limit_switch_arm_in <= 1'b1;
    st(8);
    enc.zmark();
    rd(ptl_pkg::A_POS);
    chk(rv, 32'h0000_0064);
    enc.pulses(2, 1'b0);
    enc.zmark();
    rd(ptl_pkg::A_POS);
    chk(rv, 32'h0000_0066);
    $display("test preset done");
    wr(ptl_pkg::A_END, 32'h0000_0007);
    enc.pulses(3, 1'b0);
    rd(ptl_pkg::A_END);
    chk(rv, 32'h0000_0007);
    serial_pulse_receive_in <= 1'b1;
    st(8);
    rd(ptl_pkg::A_END);
    chk(rv, 32'h0000_0000);
    enc.pulses(3, 1'b0);
    rd(ptl_pkg::A_END);
    chk(rv, 32'h0000_0003);
    serial_pulse_receive_in <= 1'b0;
    wr(ptl_pkg::A_CTRL, 32'h0000_0001);
    enc.pulses(2, 1'b0);
    rd(ptl_pkg::A_END);
    chk(rv, 32'h0000_0005);
    $display("test pulse count done");
    // Position is now 0x6E; end point placed on it, zero range
    wr(ptl_pkg::A_END, 32'h0000_006E);
    wr(ptl_pkg::A_RANGE, 32'h0000_0000);
    wr(ptl_pkg::A_ST_TMR, 32'h0000_0000);
    wr(ptl_pkg::A_END_TMR, 32'h0000_0000);
    positioning_enable_in <= 1'b1;
    run_cmd_in <= 1'b1;
    st(8);
    chk(timer_output_out, 1'b1);
    chk(drive_run_out, 1'b1);
    motor_stopped_in <= 1'b1;
    st(900);
    chk(positioning_completed_out, 1'b0);
    chk(timer_output_out, 1'b1);
    st(120);
    chk(positioning_completed_out, 1'b1);
    chk(stop_position_alarm_out, 1'b0);
    chk(timer_output_out, 1'b0);
    $display("test complete done");
    run_cmd_in <= 1'b0;
    motor_stopped_in <= 1'b0;
    return_mode_in <= 1'b1;
    wr(ptl_pkg::A_START, 32'h0000_01F4);
    st(250);
    run_cmd_in <= 1'b1;
    st(8);
    chk(reverse_dir_out, 1'b1);
    motor_stopped_in <= 1'b1;
    st(1020);
    chk(stop_position_alarm_out, 1'b1);
    chk(positioning_completed_out, 1'b0);
    rd(ptl_pkg::A_START);
    chk(rv, 32'h0000_01F4);
    rd(ptl_pkg::A_END);
    chk(rv, 32'h0000_006E);
    $display("test return done");
    run_cmd_in <= 1'b0;
    motor_stopped_in <= 1'b0;
    return_mode_in <= 1'b0;
    st(250);
    run_cmd_in <= 1'b1;
    st(8);
    motor_stopped_in <= 1'b1;
    st(100);
    run_cmd_in <= 1'b0;
    st(8);
    chk(timer_output_out, 1'b0);
    chk(drive_run_out, 1'b0);
    chk(stop_position_alarm_out, 1'b0);
    positioning_enable_in <= 1'b0;
    motor_stopped_in <= 1'b0;
    st(8);
    run_cmd_in <= 1'b1;
    st(8);
    chk(timer_output_out, 1'b0);
    $display("test cancel done");
    // Overflow with positioning disabled
    wr(ptl_pkg::A_PRESET, ptl_pkg::POS_MAX);
    limit_switch_arm_in <= 1'b0;
    st(8);
    limit_switch_arm_in <= 1'b1;
    st(8);
    enc.zmark();
    chk(position_overflow_out, 1'b0);
    enc.pulses(1, 1'b0);
    chk(position_overflow_out, 1'b1);
    rd(ptl_pkg::A_POS);
    chk(rv, 32'h0098_9680);
    enc.pulses(1, 1'b1);
    chk(position_overflow_out, 1'b0);
    enc.pulses(1, 1'b0);
    chk(position_overflow_out, 1'b1);
    // Preset beyond the limit: only the Z correction can clear the flag
    wr(ptl_pkg::A_PRESET, 32'h0098_9681);
    limit_switch_arm_in <= 1'b0;
    st(8);
    limit_switch_arm_in <= 1'b1;
    st(8);
    enc.zmark();
    chk(position_overflow_out, 1'b0);
    rd(ptl_pkg::A_POS);
    chk(rv, 32'h0098_9681);
    $display("test overflow done");
    results;
  end
endmodule
